// ==== include/pad_regs.svh ====
// Register offsets, field positions and reset values of the diagnostic bank
`ifndef PAD_REGS_SVH
`define PAD_REGS_SVH
`define PAD_ADDR_DIAG        5'h12
`define PAD_ADDR_XCVR        5'h13
`define PAD_DIAG_RESET       16'h0000
`define PAD_XCVR_RESET       16'h4000
`define PAD_RDATA_RESET      16'h0000
`define PAD_UNMAPPED_READ    16'h0000
`define PAD_BIT_FAIL         12
`define PAD_BIT_DUPLEX       11
`define PAD_BIT_RATE         10
`define PAD_BIT_SIGDET       9
`define PAD_BIT_LOCK         8
`endif

// ==== include/pad_pkg.sv ====
// Types of the diagnostic register bank
package pad_pkg;
  typedef logic [15:0] pad_word_t;
  typedef logic [4:0]  pad_addr_t;
endpackage : pad_pkg

// ==== rtl/pad_regs.sv ====
// Auto-negotiation diagnostic and transceiver gain control registers
//
// Behaviour
// - Address 0x12 is a read-only diagnostic register resetting to zero that reports the last negotiation.
// - Bit 12 is set when negotiation finds no common technology and fails.
// - The failure flag stays set until a read of the diagnostic register in a cycle without i_neg_fail clears it.
// - Bit 10 reads high for a 100BASE-TX result and low for 10BASE-T.
// - Diagnostic bits 15:13 and 7:0 read as zero and software must not rely on them.
// - Address 0x13 is a read/write transceiver control register resetting to 0x4000.
// - The transceiver control register holds the transmit output gain setting.
// - All registers can be polled by single reads over the management access.
`timescale 1ns/1ps
`include "pad_regs.svh"

module pad_regs
  import pad_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clk_sys,
  input  wire logic      i_reset_n,
  // Management register access
  input  wire logic      i_mgmt_rd,
  input  wire logic      i_mgmt_wr,
  input  wire pad_addr_t i_mgmt_addr,
  input  wire pad_word_t i_mgmt_wdata,
  output pad_word_t      o_mgmt_rdata,
  // Negotiation results from the PHY core, same clock
  input  wire logic      i_neg_done,
  input  wire logic      i_neg_fail,
  input  wire logic      i_neg_full_duplex,
  input  wire logic      i_neg_rate_100,
  input  wire logic      i_receive_signal_detect,
  input  wire logic      i_rx_lock,
  // Transmit gain setting
  output pad_word_t      o_tx_gain_ctrl
);

  // Address match against one register offset
  function automatic logic pad_addr_hit(
    input pad_addr_t addr,
    input pad_addr_t target
  );
    return (addr == target);
  endfunction : pad_addr_hit

  // Diagnostic word with reserved bits held at zero
  function automatic pad_word_t pad_diag_pack(
    input logic fail,
    input logic duplex,
    input logic rate,
    input logic sigdet,
    input logic lock
  );
    pad_word_t word;
    word                  = `PAD_DIAG_RESET;
    word[`PAD_BIT_FAIL]   = fail;
    word[`PAD_BIT_DUPLEX] = duplex;
    word[`PAD_BIT_RATE]   = rate;
    word[`PAD_BIT_SIGDET] = sigdet;
    word[`PAD_BIT_LOCK]   = lock;
    return word;
  endfunction : pad_diag_pack

  // Unmapped addresses read as zero
  function automatic pad_word_t pad_read_select(
    input logic      hit_diag,
    input logic      hit_xcvr,
    input pad_word_t diag,
    input pad_word_t gain
  );
    pad_word_t word;
    word = `PAD_UNMAPPED_READ;
    case ({hit_diag, hit_xcvr})
      2'h2:    word = diag;
      2'h1:    word = gain;
      default: word = `PAD_UNMAPPED_READ;
    endcase
    return word;
  endfunction : pad_read_select

  // Diagnostic state
  logic      negotiation_failed_flag_reg;
  logic      negotiation_failed_flag_next;
  logic      negotiated_duplex_reg;
  logic      negotiated_duplex_next;
  logic      rate_reg;
  logic      rate_next;
  logic      receive_signal_detect_reg;
  logic      receive_signal_detect_next;
  logic      lock_reg;
  logic      lock_next;

  // Transceiver control state
  pad_word_t gain_reg;
  pad_word_t gain_next;

  // Read data state
  pad_word_t rdata_reg;
  pad_word_t rdata_next;

  // Decode and selection
  logic      sel_diag;
  logic      sel_xcvr;
  logic      diag_read;
  logic      gain_write;
  pad_word_t diag_word;
  pad_word_t read_word;

  // Failure flag terms
  logic      fail_set;
  logic      fail_keep;

  // Address decode
  assign sel_diag   = pad_addr_hit(i_mgmt_addr, `PAD_ADDR_DIAG);
  assign sel_xcvr   = pad_addr_hit(i_mgmt_addr, `PAD_ADDR_XCVR);

  // Strobes qualified by address
  assign diag_read  = i_mgmt_rd && sel_diag;
  assign gain_write = i_mgmt_wr && sel_xcvr;

  assign diag_word = pad_diag_pack(
    negotiation_failed_flag_reg,
    negotiated_duplex_reg,
    rate_reg,
    receive_signal_detect_reg,
    lock_reg
  );

  assign read_word = pad_read_select(
    sel_diag,
    sel_xcvr,
    diag_word,
    gain_reg
  );

  // Set wins over a read clear in the same cycle
  assign fail_set                     = i_neg_fail;
  assign fail_keep                    = negotiation_failed_flag_reg & ~diag_read;
  assign negotiation_failed_flag_next = fail_set | fail_keep;

  // Results latch on completion and hold until the next one
  assign negotiated_duplex_next = i_neg_done ? i_neg_full_duplex
                                             : negotiated_duplex_reg;
  assign rate_next              = i_neg_done ? i_neg_rate_100
                                             : rate_reg;

  // Line status follows its inputs one cycle later
  assign receive_signal_detect_next = i_receive_signal_detect;
  assign lock_next                  = i_rx_lock;

  // Writes to any other address are ignored
  assign gain_next = gain_write ? i_mgmt_wdata
                                : gain_reg;

  // Read data holds until the next read strobe
  assign rdata_next = i_mgmt_rd ? read_word
                                : rdata_reg;

  // Failure flag
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      negotiation_failed_flag_reg <= 1'h0;
    end else begin
      negotiation_failed_flag_reg <= negotiation_failed_flag_next;
    end
  end

  // Negotiated duplex
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      negotiated_duplex_reg <= 1'h0;
    end else begin
      negotiated_duplex_reg <= negotiated_duplex_next;
    end
  end

  // Negotiated rate
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rate_reg <= 1'h0;
    end else begin
      rate_reg <= rate_next;
    end
  end

  // Receive signal detect
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      receive_signal_detect_reg <= 1'h0;
    end else begin
      receive_signal_detect_reg <= receive_signal_detect_next;
    end
  end

  // Receiver lock
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_reg <= 1'h0;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // Transmit gain control
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gain_reg <= `PAD_XCVR_RESET;
    end else begin
      gain_reg <= gain_next;
    end
  end

  // Read data
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= `PAD_RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Register outputs
  assign o_mgmt_rdata   = rdata_reg;
  assign o_tx_gain_ctrl = gain_reg;

endmodule : pad_regs

// ==== tb/pad_mgmt_master.sv ====
// Management master model driving the register strobes
`timescale 1ns/1ps
module pad_mgmt_master import pad_pkg::*; (input wire logic clk, output logic rd, wr,
  output pad_addr_t addr, output pad_word_t wd);
  initial {rd, wr, addr, wd} = '0;
  // One strobe per transfer, released address inverted
  task automatic xfer(input logic w, input pad_addr_t a, input pad_word_t d);
    @(negedge clk); rd = !w; wr = w; addr = a; wd = d;
    @(negedge clk); rd = 0; wr = 0; addr = ~a; wd = ~d;
  endtask : xfer
endmodule : pad_mgmt_master

// ==== tb/pad_regs_properties.sv ====
// Checker for the diagnostic bank
`timescale 1ns/1ps
module pad_regs_properties import pad_pkg::*; (input wire logic i_clk_sys, i_reset_n,
  i_mgmt_rd, i_mgmt_wr, i_neg_fail, input wire pad_addr_t i_mgmt_addr,
  input wire pad_word_t i_mgmt_wdata, o_mgmt_rdata, o_tx_gain_ctrl);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_reserved_zero: assert property (i_mgmt_rd && i_mgmt_addr == 5'h12 |=>
    o_mgmt_rdata[15:13] == 3'h0 && o_mgmt_rdata[7:0] == 8'h00) else $error("reserved set");
  a_gain_write: assert property (i_mgmt_wr && i_mgmt_addr == 5'h13 |=>
    o_tx_gain_ctrl == $past(i_mgmt_wdata)) else $error("gain not written");
  a_fail_seen: assert property (i_neg_fail ##1 i_mgmt_rd && i_mgmt_addr == 5'h12 |=>
    o_mgmt_rdata[12]) else $error("fail flag lost");
  a_read_clears: assert property (i_mgmt_rd && i_mgmt_addr == 5'h12 && !i_neg_fail ##1
    !i_neg_fail ##1 i_mgmt_rd && i_mgmt_addr == 5'h12 && !i_neg_fail |=> !o_mgmt_rdata[12])
    else $error("fail flag kept");
  a_unmapped_zero: assert property (i_mgmt_rd && i_mgmt_addr != 5'h12 &&
    i_mgmt_addr != 5'h13 |=> o_mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!i_mgmt_rd |=> $stable(o_mgmt_rdata))
    else $error("read data changed without read");
  a_gain_stable: assert property (!(i_mgmt_wr && i_mgmt_addr == 5'h13) |=>
    $stable(o_tx_gain_ctrl)) else $error("gain changed without write");
  a_gain_read: assert property (i_mgmt_rd && !i_mgmt_wr && i_mgmt_addr == 5'h13 |=>
    o_mgmt_rdata == $past(o_tx_gain_ctrl)) else $error("gain readback");
endmodule : pad_regs_properties
bind pad_regs pad_regs_properties u_props (.*);

// ==== tb/tb_phy_autoneg_diagnostic_regs.sv ====
// Bench for the diagnostic register bank
`timescale 1ns/1ps
module tb_phy_autoneg_diagnostic_regs;
  import pad_pkg::*;
  logic clk = 0, rst_n = 0, rd, wr, done = 0, fail = 0, dpx = 0, r100 = 0, sd = 0, lk = 0;
  pad_addr_t a;
  pad_word_t wd, rdata, gain, lf = 16'h4F17;
  int err_count = 0, n_compared = 0;
  initial forever #12.5 clk = ~clk;
  pad_mgmt_master m (.clk(clk), .rd(rd), .wr(wr), .addr(a), .wd(wd));
  pad_regs dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_mgmt_rd(rd), .i_mgmt_wr(wr),
    .i_mgmt_addr(a), .i_mgmt_wdata(wd), .o_mgmt_rdata(rdata), .i_neg_done(done),
    .i_neg_fail(fail), .i_neg_full_duplex(dpx), .i_neg_rate_100(r100),
    .i_receive_signal_detect(sd), .i_rx_lock(lk), .o_tx_gain_ctrl(gain));
  function pad_word_t nxt(pad_word_t v); return {v[14:0], ^(v & 16'hB400)}; endfunction : nxt
  function pad_word_t diag(logic f, d, r, s, l); return {3'h0, f, d, r, s, l, 8'h00};
  endfunction : diag
  task chk(input string n, input pad_word_t e, g);
    n_compared++;
    if (g !== e) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end
  endtask : chk
  task rdc(input pad_addr_t ad, input pad_word_t e); m.xfer(0, ad, '0); chk("rdata", e, rdata);
  endtask : rdc
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    chk("rdata", 16'h0000, rdata);
    chk("gain", 16'h4000, gain);
    rdc(5'h12, 16'h0000);
    rdc(5'h13, 16'h4000);
    rdc(5'h1F, 16'h0000);
    repeat (8) begin
      lf = nxt(lf);
      m.xfer(1, 5'h13, lf);
      chk("gain", lf, gain);
      rdc(5'h13, lf);
    end
    m.xfer(1, 5'h12, 16'hFFFF);
    chk("gain", lf, gain);
    rdc(5'h12, diag(0, 0, 0, 0, 0));
    @(negedge clk); fail = 1;
    @(negedge clk); fail = 0;
    rdc(5'h12, diag(1, 0, 0, 0, 0));
    rdc(5'h12, diag(0, 0, 0, 0, 0));
    fail = 1;
    rdc(5'h12, diag(1, 0, 0, 0, 0));
    fail = 0;
    rdc(5'h12, diag(1, 0, 0, 0, 0));
    rdc(5'h12, diag(0, 0, 0, 0, 0));
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      @(negedge clk); {dpx, r100} = i[1:0]; {sd, lk} = lf[1:0]; done = 1;
      @(negedge clk); done = 0; {dpx, r100} = lf[3:2];
      rdc(5'h12, diag(0, i[1], i[0], lf[1], lf[0]));
    end
    fail = 1;
    m.xfer(1, 5'h13, ~lf);
    rst_n = 0;
    @(negedge clk);
    chk("gain", 16'h4000, gain);
    chk("rdata", 16'h0000, rdata);
    rst_n = 1;
    fail = 0;
    rdc(5'h12, diag(0, 0, 0, lf[1], lf[0]));
    conclude;
  end
endmodule : tb_phy_autoneg_diagnostic_regs
